// ---- rtl/pwmdb_pkg.sv ----
// Constants shared by the PWM unit and its dead-band stage
package pwmdb_pkg;
  localparam int NGEN = 3;
  localparam int CNT_W = 16;
  localparam int DB_W = 12;
  localparam int OUT_N = 6;
  localparam int EV_N = 6;
  localparam int CTL_W = 6;
  localparam int GEN_W = 12;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // Global register byte offsets
  localparam logic [7:0] A_UPD = 8'h00;
  localparam logic [7:0] A_SYNC = 8'h04;
  localparam logic [7:0] A_ENABLE = 8'h08;
  localparam logic [7:0] A_INVERT = 8'h0c;
  localparam logic [7:0] A_FAULT = 8'h10;
  localparam logic [7:0] A_INTEN = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h20;
  // Generator register offsets inside a 64-byte block
  localparam logic [5:0] O_CTL = 6'h00;
  localparam logic [5:0] O_INTEN = 6'h04;
  localparam logic [5:0] O_LOAD = 6'h10;
  localparam logic [5:0] O_COUNT = 6'h14;
  localparam logic [5:0] O_CMPA = 6'h18;
  localparam logic [5:0] O_CMPB = 6'h1c;
  localparam logic [5:0] O_GENA = 6'h20;
  localparam logic [5:0] O_GENB = 6'h24;
  localparam logic [5:0] O_DBCTL = 6'h28;
  localparam logic [5:0] O_DBRISE = 6'h2c;
  localparam logic [5:0] O_DBFALL = 6'h30;
  // Generator control bits; C_USYNC..+2 select synced update of load, A, B
  localparam int C_RUN = 0;
  localparam int C_MODE = 1;
  localparam int C_KEEP = 2;
  localparam int C_USYNC = 3;
  // Event bits
  localparam int E_ZERO = 0;
  localparam int E_LOAD = 1;
  localparam int E_AUP = 2;
  localparam int E_ADN = 3;
  localparam int E_BUP = 4;
  localparam int E_BDN = 5;
  localparam logic [5:0] EV_A_MASK = 6'h0c;
  localparam logic [5:0] EV_B_MASK = 6'h30;
  // Status bits
  localparam int S_FAULT = 0;
  localparam int S_DIR = 1;
  localparam int I_FAULT = 0;
  // Per-event output action
  typedef enum logic [1:0] {
    PWMDB_ACT_NONE = 2'h0,
    PWMDB_ACT_TOG = 2'h1,
    PWMDB_ACT_LOW = 2'h2,
    PWMDB_ACT_HIGH = 2'h3
  } pwmdb_act_t;
endpackage

// ---- rtl/pwmdb_deadband.sv ----
// Dead-band stage: pass-through or complementary pair with edge delays
`timescale 1ns/1ps
module pwmdb_deadband #(
  parameter int DW = pwmdb_pkg::DB_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_en,
  input wire logic i_a,
  input wire logic i_b,
  input wire logic [DW-1:0] i_rise,
  input wire logic [DW-1:0] i_fall,
  output logic o_a,
  output logic o_b
);
  logic [DW-1:0] rc_q, fc_q;
  logic a_q, b_q;
  wire [DW-1:0] rc_d = !i_a ? '0 : (&rc_q ? rc_q : rc_q + 1'b1);
  wire [DW-1:0] fc_d = i_a ? '0 : (&fc_q ? fc_q : fc_q + 1'b1);
  wire a_d = i_en ? (i_a && rc_q >= i_rise) : i_a;
  wire b_d = i_en ? (!i_a && fc_q >= i_fall) : i_b;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rc_q <= '0;
      fc_q <= '0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      rc_q <= rc_d;
      fc_q <= fc_d;
      a_q <= a_d;
      b_q <= b_d;
    end
  end
  assign o_a = a_q;
  assign o_b = b_q;

  //////////////////////////////////////////////////////////////////////////////
  // Disabled passes through
  property p_db_pass;
    @(posedge i_clk) disable iff (!i_resetn)
    !i_en |=> o_a == $past(i_a) && o_b == $past(i_b);
  endproperty
  a_db_pass: assert property (p_db_pass) else $error("dead-band bypass differs");
  property p_db_fall;
    @(posedge i_clk) disable iff (!i_resetn)
    i_en && !i_a |=> !o_a;
  endproperty
  a_db_fall: assert property (p_db_fall) else $error("first output late to fall");
endmodule // pwmdb_deadband

// ---- rtl/pwmdb_top.sv ----
// Three-generator PWM unit with counters, actions, dead-band and faults
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Three generators, 16-bit counter, two comparators
// - Down mode counts load to zero, reloads
// - Up/down mode bounces between zero and load
// - Direction low in down mode, tracks otherwise
// - Zero and load pulses; load follows zero
// - Match pulses, direction-qualified in up/down mode
// - Match above load never fires
// - Four events down, six events up/down
// - Matches ignored alongside zero or load
// - Coinciding matches: A drives first, B second
// - Per-event action: keep, toggle, low, high
// - Dead-band disabled passes both outputs unchanged
// - Dead-band first output delays rising edges
// - Second output inverted, delayed after falling edge
// - Any enabled event raises generator interrupt
// - Interrupts use raw events, not delayed
// - Global reset clears selected counters together
// - Immediate update applies at next zero
// - Synced update waits for global strobe
// - Update mode chosen per value per generator
// - Fault forces enabled outputs inactive, may interrupt
// - Stall: keep running or halt at zero
// - Output enable gating and optional inversion
module pwmdb_top #(
  parameter int CW = pwmdb_pkg::CNT_W,
  parameter int DW = pwmdb_pkg::DB_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [pwmdb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pwmdb_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pwmdb_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_fault,
  input wire logic i_stall,
  output logic [pwmdb_pkg::OUT_N-1:0] o_pwm,
  output logic [pwmdb_pkg::NGEN-1:0] o_gen_irq,
  output logic o_fault_irq
);
  localparam int NG = pwmdb_pkg::NGEN;
  localparam int NO = pwmdb_pkg::OUT_N;
  localparam int DA = pwmdb_pkg::DATA_W;

  if (CW < 2 || CW > 16 || DW < 1 || DW > 16)
  begin : gen_bad_width
    $error("counter or delay width out of range");
  end

  function automatic logic act_fn(input logic cur, input logic [1:0] code);
    unique case (pwmdb_pkg::pwmdb_act_t'(code))
      pwmdb_pkg::PWMDB_ACT_NONE: act_fn = cur;
      pwmdb_pkg::PWMDB_ACT_TOG: act_fn = ~cur;
      pwmdb_pkg::PWMDB_ACT_LOW: act_fn = 1'b0;
      pwmdb_pkg::PWMDB_ACT_HIGH: act_fn = 1'b1;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Global registers and bus decode
  logic [NO-1:0] en_q, inv_q, fen_q, pin_q;
  logic fint_q, f1_q, f2_q, f3_q, fault_q, firq_q;
  logic [DA-1:0] rdata_q;
  logic [DA-1:0] gen_rd [NG];
  wire [NO-1:0] raw;
  wire [NG-1:0] dirs;
  wire [1:0] blk = i_addr[7:6];
  wire [5:0] off = i_addr[5:0];
  wire gsel = blk == 2'h0;
  wire gwr = i_wr && gsel;
  wire [NG-1:0] gupd = (gwr && i_addr == pwmdb_pkg::A_UPD) ? i_wdata[NG-1:0] : '0;
  wire [NG-1:0] sreset = (gwr && i_addr == pwmdb_pkg::A_SYNC) ? i_wdata[NG-1:0] : '0;
  // Fault counts once the second and third stages agree
  wire fault_d = (f2_q == f3_q) ? f3_q : fault_q;
  wire [DA-1:0] glob_rd =
    i_addr == pwmdb_pkg::A_ENABLE ? DA'(en_q) :
    i_addr == pwmdb_pkg::A_INVERT ? DA'(inv_q) :
    i_addr == pwmdb_pkg::A_FAULT ? DA'(fen_q) :
    i_addr == pwmdb_pkg::A_INTEN ? DA'(fint_q) :
    i_addr == pwmdb_pkg::A_STATUS ? DA'({dirs, fault_q}) : '0;
  wire [1:0] gidx = blk - 2'h1;
  wire [DA-1:0] rd_mux = gsel ? glob_rd : gen_rd[gidx];
  wire [NO-1:0] safe = raw & ~({NO{fault_q}} & fen_q);
  wire [NO-1:0] pin_d = en_q & (safe ^ inv_q);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      en_q <= '0;
      inv_q <= '0;
      fen_q <= '0;
      fint_q <= 1'b0;
      f1_q <= 1'b0;
      f2_q <= 1'b0;
      f3_q <= 1'b0;
      fault_q <= 1'b0;
      firq_q <= 1'b0;
      pin_q <= '0;
      rdata_q <= '0;
    end
    else
    begin
      if (gwr && i_addr == pwmdb_pkg::A_ENABLE) en_q <= i_wdata[NO-1:0];
      if (gwr && i_addr == pwmdb_pkg::A_INVERT) inv_q <= i_wdata[NO-1:0];
      if (gwr && i_addr == pwmdb_pkg::A_FAULT) fen_q <= i_wdata[NO-1:0];
      if (gwr && i_addr == pwmdb_pkg::A_INTEN) fint_q <= i_wdata[pwmdb_pkg::I_FAULT];
      f1_q <= i_fault;
      f2_q <= f1_q;
      f3_q <= f2_q;
      fault_q <= fault_d;
      firq_q <= fault_d && !fault_q && fint_q;
      pin_q <= pin_d;
      rdata_q <= i_rd ? rd_mux : '0;
    end
  end
  assign o_pwm = pin_q;
  assign o_fault_irq = firq_q;
  assign o_rdata = rdata_q;

  property p_fault_force;
    @(posedge i_clk) disable iff (!i_resetn)
    fault_q && fen_q[0] && en_q[0] && !inv_q[0] |=> !o_pwm[0];
  endproperty
  a_fault_force: assert property (p_fault_force) else $error("fault did not force low");

  //////////////////////////////////////////////////////////////////////////////
  // Generator blocks
  // Three identical generators
  for (genvar g = 0; g < NG; g++)
  begin : gen_blk
    localparam logic [1:0] GI = 2'(g + 1);
    logic [pwmdb_pkg::CTL_W-1:0] ctl_q;
    logic [pwmdb_pkg::EV_N-1:0] inten_q, ev, eva, evb;
    logic [pwmdb_pkg::GEN_W-1:0] gena_q, genb_q;
    logic [DW-1:0] rise_q, fall_q;
    logic [CW-1:0] sh_q [3];
    logic [CW-1:0] act_q [3];
    logic [2:0] rdy_q, wait_q, rdy_d, wait_d, vwr, usync;
    logic [CW-1:0] cnt_q, cnt_d;
    logic dir_q, dir_d, hold_q, pa_q, pb_q, pa_d, pb_d, irq_q, db_q;
    wire wr = i_wr && blk == GI;
    wire at_zero = cnt_q == '0;
    wire at_load = cnt_q == act_q[0];
    // Reload takes a value applied at this same zero
    wire [CW-1:0] load_nx = (at_zero && rdy_q[0]) ? sh_q[0] : act_q[0];
    wire mode = ctl_q[pwmdb_pkg::C_MODE];
    wire run_ok = ctl_q[pwmdb_pkg::C_RUN] && !hold_q;
    // Stall halts at zero unless kept running
    wire adv = ctl_q[pwmdb_pkg::C_RUN]
      && !(i_stall && !ctl_q[pwmdb_pkg::C_KEEP] && at_zero);
    wire ma = cnt_q == act_q[1] && act_q[1] <= act_q[0];
    wire mb = cnt_q == act_q[2] && act_q[2] <= act_q[0];
    wire m_ok = run_ok && !at_zero && !at_load;

    assign vwr = {wr && off == pwmdb_pkg::O_CMPB, wr && off == pwmdb_pkg::O_CMPA,
                  wr && off == pwmdb_pkg::O_LOAD};
    assign usync = ctl_q[pwmdb_pkg::C_USYNC +: 3];
    assign rdy_d = (vwr & ~usync) | (wait_q & {3{gupd[g]}}) | (rdy_q & ~{3{at_zero}});
    assign wait_d = (vwr & usync) | (wait_q & ~{3{gupd[g]}});

    assign ev[pwmdb_pkg::E_ZERO] = run_ok && at_zero;
    assign ev[pwmdb_pkg::E_LOAD] = run_ok && at_load;
    assign ev[pwmdb_pkg::E_AUP] = m_ok && ma && dir_q;
    assign ev[pwmdb_pkg::E_ADN] = m_ok && ma && !dir_q;
    assign ev[pwmdb_pkg::E_BUP] = m_ok && mb && dir_q;
    assign ev[pwmdb_pkg::E_BDN] = m_ok && mb && !dir_q;
    wire both = |(ev & pwmdb_pkg::EV_A_MASK) && |(ev & pwmdb_pkg::EV_B_MASK);
    assign eva = ev & ~({pwmdb_pkg::EV_N{both}} & pwmdb_pkg::EV_B_MASK);
    assign evb = ev & ~({pwmdb_pkg::EV_N{both}} & pwmdb_pkg::EV_A_MASK);

    always_comb
    begin
      cnt_d = cnt_q;
      dir_d = mode ? dir_q : 1'b0;
      if (sreset[g])
      begin
        cnt_d = '0;
        dir_d = 1'b0;
      end
      else if (adv && !mode)
      begin
        cnt_d = at_zero ? load_nx : cnt_q - 1'b1;
      end
      else if (adv)
      begin
        dir_d = at_zero ? 1'b1 : (at_load ? 1'b0 : dir_q);
        if (load_nx == '0)
          cnt_d = '0;
        else
          cnt_d = dir_d ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
    end

    always_comb
    begin
      pa_d = pa_q;
      pb_d = pb_q;
      for (int e = 0; e < pwmdb_pkg::EV_N; e++)
      begin
        if (eva[e]) pa_d = act_fn(pa_d, gena_q[2*e +: 2]);
        if (evb[e]) pb_d = act_fn(pb_d, genb_q[2*e +: 2]);
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        ctl_q <= '0;
        inten_q <= '0;
        gena_q <= '0;
        genb_q <= '0;
        db_q <= 1'b0;
        rise_q <= '0;
        fall_q <= '0;
        sh_q <= '{default: '0};
        act_q <= '{default: '0};
        rdy_q <= '0;
        wait_q <= '0;
        cnt_q <= '0;
        dir_q <= 1'b0;
        hold_q <= 1'b0;
        pa_q <= 1'b0;
        pb_q <= 1'b0;
        irq_q <= 1'b0;
      end
      else
      begin
        if (wr && off == pwmdb_pkg::O_CTL) ctl_q <= i_wdata[pwmdb_pkg::CTL_W-1:0];
        if (wr && off == pwmdb_pkg::O_INTEN) inten_q <= i_wdata[pwmdb_pkg::EV_N-1:0];
        if (wr && off == pwmdb_pkg::O_GENA) gena_q <= i_wdata[pwmdb_pkg::GEN_W-1:0];
        if (wr && off == pwmdb_pkg::O_GENB) genb_q <= i_wdata[pwmdb_pkg::GEN_W-1:0];
        if (wr && off == pwmdb_pkg::O_DBCTL) db_q <= i_wdata[0];
        if (wr && off == pwmdb_pkg::O_DBRISE) rise_q <= i_wdata[DW-1:0];
        if (wr && off == pwmdb_pkg::O_DBFALL) fall_q <= i_wdata[DW-1:0];
        for (int v = 0; v < 3; v++)
        begin
          if (vwr[v]) sh_q[v] <= i_wdata[CW-1:0];
          if (at_zero && rdy_q[v]) act_q[v] <= sh_q[v];
        end
        rdy_q <= rdy_d;
        wait_q <= wait_d;
        cnt_q <= cnt_d;
        dir_q <= dir_d;
        hold_q <= ctl_q[pwmdb_pkg::C_RUN] && !adv;
        pa_q <= pa_d;
        pb_q <= pb_d;
        irq_q <= |(ev & inten_q);
      end
    end

    pwmdb_deadband #(
      .DW(DW)
    ) u_db (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_en(db_q),
      .i_a(pa_q),
      .i_b(pb_q),
      .i_rise(rise_q),
      .i_fall(fall_q),
      .o_a(raw[2*g]),
      .o_b(raw[2*g+1])
    );

    assign dirs[g] = dir_q;
    assign o_gen_irq[g] = irq_q;
    assign gen_rd[g] =
      off == pwmdb_pkg::O_CTL ? DA'(ctl_q) :
      off == pwmdb_pkg::O_INTEN ? DA'(inten_q) :
      off == pwmdb_pkg::O_LOAD ? DA'(sh_q[0]) :
      off == pwmdb_pkg::O_COUNT ? DA'(cnt_q) :
      off == pwmdb_pkg::O_CMPA ? DA'(sh_q[1]) :
      off == pwmdb_pkg::O_CMPB ? DA'(sh_q[2]) :
      off == pwmdb_pkg::O_GENA ? DA'(gena_q) :
      off == pwmdb_pkg::O_GENB ? DA'(genb_q) :
      off == pwmdb_pkg::O_DBCTL ? DA'(db_q) :
      off == pwmdb_pkg::O_DBRISE ? DA'(rise_q) :
      off == pwmdb_pkg::O_DBFALL ? DA'(fall_q) : '0;

    property p_down_reload;
      @(posedge i_clk) disable iff (!i_resetn)
      adv && !mode && at_zero && !sreset[g] |=> cnt_q == act_q[0];
    endproperty
    a_down_reload: assert property (p_down_reload) else $error("no reload at zero");
    property p_zero_load;
      @(posedge i_clk) disable iff (!i_resetn)
      ev[pwmdb_pkg::E_ZERO] && adv && !mode && act_q[0] != '0 && !sreset[g]
        && !(wr && off == pwmdb_pkg::O_CTL) |=> ev[pwmdb_pkg::E_LOAD];
    endproperty
    a_zero_load: assert property (p_zero_load) else $error("load pulse missing");
    property p_turn_down;
      @(posedge i_clk) disable iff (!i_resetn)
      adv && mode && at_load && !at_zero && !sreset[g] |=> cnt_q == CW'($past(cnt_q) - 1'b1);
    endproperty
    a_turn_down: assert property (p_turn_down) else $error("no turn at load");
    property p_dir_low;
      @(posedge i_clk) disable iff (!i_resetn)
      !mode && $past(!mode) |-> !dir_q;
    endproperty
    a_dir_low: assert property (p_dir_low) else $error("direction high in down mode");
    property p_no_match;
      @(posedge i_clk) disable iff (!i_resetn)
      act_q[1] > act_q[0] |-> !ev[pwmdb_pkg::E_AUP] && !ev[pwmdb_pkg::E_ADN];
    endproperty
    a_no_match: assert property (p_no_match) else $error("match above load");
    property p_sreset;
      @(posedge i_clk) disable iff (!i_resetn)
      sreset[g] |=> cnt_q == '0 && !dir_q;
    endproperty
    a_sreset: assert property (p_sreset) else $error("counter not cleared");
    property p_sync_hold;
      @(posedge i_clk) disable iff (!i_resetn)
      wait_q[0] && !rdy_q[0] && !gupd[g] |=> $stable(act_q[0]);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("synced load applied early");
    property p_irq;
      @(posedge i_clk) disable iff (!i_resetn)
      |(ev & inten_q) |=> o_gen_irq[g] ##1 (o_gen_irq[g] == $past(|(ev & inten_q)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
  end
endmodule // pwmdb_top

// ---- verif/pwmdb_gate_model.sv ----
// Gate-driver stand-in that counts high cycles on each pin
`timescale 1ns/1ps
module pwmdb_gate_model (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic [pwmdb_pkg::OUT_N-1:0] i_pins,
  output logic [pwmdb_pkg::OUT_N-1:0][15:0] o_hi
);
  // A power stage only sees levels, so duty is judged by high time
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < pwmdb_pkg::OUT_N; k++)
    begin
      o_hi[k] <= i_clr ? 16'h0 : o_hi[k] + 16'(i_pins[k]);
    end
  end
endmodule // pwmdb_gate_model

// ---- verif/tb.sv ----
// Self-checking bench for the three-generator PWM unit
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_fault = 1'b0;
  logic i_stall = 1'b0;
  logic clr = 1'b1;
  logic [31:0] o_rdata;
  logic [5:0] o_pwm;
  logic [2:0] o_gen_irq;
  logic o_fault_irq;
  logic [5:0][15:0] hi;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int nfirq = 0;
  logic [31:0] d;
  logic [31:0] c0;
  int a;
  int b;

  always #10 i_clk = ~i_clk;

  pwmdb_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault(i_fault), .i_stall(i_stall),
    .o_pwm(o_pwm), .o_gen_irq(o_gen_irq), .o_fault_irq(o_fault_irq));
  pwmdb_gate_model drv (.i_clk(i_clk), .i_clr(clr), .i_pins(o_pwm), .o_hi(hi));

  ////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (o_fault_irq === 1'b1)
      nfirq <= nfirq + 1;
    if (cycles == 20000)
    begin
      num_errors += 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  function automatic logic [7:0] adr(input int g, input logic [5:0] off);
    return 8'((g + 1) * 64) + 8'(off);
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= ad;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic rst();
    @(posedge i_clk);
    i_resetn <= 1'b0;
    i_fault <= 1'b0;
    i_stall <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
  endtask

  task automatic gen(input int g, input logic [31:0] ctl, ld, ca, cb, xa, xb, ie);
    wr(adr(g, pwmdb_pkg::O_LOAD), ld);
    wr(adr(g, pwmdb_pkg::O_CMPA), ca);
    wr(adr(g, pwmdb_pkg::O_CMPB), cb);
    wr(adr(g, pwmdb_pkg::O_GENA), xa);
    wr(adr(g, pwmdb_pkg::O_GENB), xb);
    wr(adr(g, pwmdb_pkg::O_INTEN), ie);
    wr(adr(g, pwmdb_pkg::O_CTL), ctl);
  endtask

  // Cycles until the next interrupt pulse, 200 meaning none
  task automatic nxt(input int g, output int n);
    n = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    while (o_gen_irq[g] !== 1'b1 && n < 200);
  endtask

  task automatic gaps(input int g, output int x, output int y);
    nxt(g, x);
    nxt(g, x);
    nxt(g, y);
  endtask

  task automatic win(input int n);
    @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic act(input logic [31:0] xa, xb, ca, cb, input int e0, e1);
    rst();
    gen(0, 32'h1, 32'h7, ca, cb, xa, xb, 32'h0);
    wr(pwmdb_pkg::A_ENABLE, 32'h3f);
    repeat (32) @(posedge i_clk);
    win(64);
    chk(32'(hi[0]), 32'(e0), "first output high time");
    chk(32'(hi[1]), 32'(e1), "second output high time");
  endtask

  ////////////////////////////////////////
  initial
  begin
    rst();
    chk(32'(o_pwm), 32'h0, "pins after reset");
    rd(adr(0, pwmdb_pkg::O_COUNT), d);
    chk(d, 32'h0, "count after reset");
    rd(adr(1, pwmdb_pkg::O_DBCTL), d);
    chk(d, 32'h0, "dead-band control after reset");
    rd(8'hfc, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");

    gen(0, 32'h1, 32'h3, 32'h1, 32'h2, 32'h0, 32'h0, 32'h1);
    gaps(0, a, b);
    chk(32'(b), 32'h4, "down period");
    wr(adr(0, pwmdb_pkg::O_INTEN), 32'h3);
    gaps(0, a, b);
    chk(32'(a + b), 32'h4, "zero and load spacing");
    chk(32'(a < b ? a : b), 32'h1, "load after zero");
    wr(adr(0, pwmdb_pkg::O_INTEN), 32'h4);
    gaps(0, a, b);
    chk(32'(b), 32'd200, "no up match when counting down");
    wr(adr(0, pwmdb_pkg::O_INTEN), 32'h8);
    gaps(0, a, b);
    chk(32'(b), 32'h4, "down match period");
    wr(adr(0, pwmdb_pkg::O_CTL), 32'h3);
    wr(adr(0, pwmdb_pkg::O_INTEN), 32'h1);
    gaps(0, a, b);
    chk(32'(b), 32'h6, "up/down period");
    wr(adr(0, pwmdb_pkg::O_INTEN), 32'hc);
    gaps(0, a, b);
    chk(32'(a + b), 32'h6, "up and down match spacing");
    chk(32'(a < b ? a : b), 32'h2, "up then down match");
    $display("test counter done");

    act(32'h083, 32'h001, 32'h3, 32'h3, 40, 32);
    act(32'h8c2, 32'hc80, 32'h3, 32'h3, 24, 64);
    act(32'h0c0, 32'h0, 32'h8, 32'h8, 0, 0);
    act(32'h0c2, 32'h0, 32'h0, 32'h0, 0, 0);
    $display("test actions done");

    rst();
    gen(0, 32'h1, 32'h7, 32'h3, 32'h3, 32'h083, 32'h001, 32'h0);
    wr(adr(0, pwmdb_pkg::O_DBRISE), 32'h2);
    wr(adr(0, pwmdb_pkg::O_DBFALL), 32'h1);
    wr(adr(0, pwmdb_pkg::O_DBCTL), 32'h1);
    wr(pwmdb_pkg::A_ENABLE, 32'h3f);
    repeat (32) @(posedge i_clk);
    win(64);
    chk(32'(hi[0]), 32'd24, "delayed first output");
    chk(32'(hi[1]), 32'd16, "delayed inverse output");
    $display("test dead-band done");

    gen(1, 32'h1, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
    wr(pwmdb_pkg::A_SYNC, 32'h3);
    rd(adr(0, pwmdb_pkg::O_COUNT), c0);
    rd(adr(1, pwmdb_pkg::O_COUNT), d);
    chk(d, (c0 + 32'h6) % 32'h8, "counts after global reset");
    $display("test global reset done");

    rst();
    gen(0, 32'h1, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1);
    wr(adr(0, pwmdb_pkg::O_LOAD), 32'h5);
    gaps(0, a, b);
    chk(32'(b), 32'h6, "immediate load update");
    wr(adr(0, pwmdb_pkg::O_CTL), 32'h9);
    wr(adr(0, pwmdb_pkg::O_LOAD), 32'h3);
    gaps(0, a, b);
    chk(32'(b), 32'h6, "synced load held");
    wr(pwmdb_pkg::A_UPD, 32'h1);
    gaps(0, a, b);
    chk(32'(b), 32'h4, "synced load applied");
    $display("test update done");

    rst();
    gen(0, 32'h1, 32'h7, 32'h0, 32'h0, 32'h003, 32'h003, 32'h0);
    wr(pwmdb_pkg::A_ENABLE, 32'h3f);
    wr(pwmdb_pkg::A_FAULT, 32'h01);
    wr(pwmdb_pkg::A_INTEN, 32'h1);
    @(posedge i_clk);
    i_fault <= 1'b1;
    repeat (10) @(posedge i_clk);
    win(16);
    chk(32'(hi[0]), 32'h0, "faulted pin");
    chk(32'(hi[1]), 32'd16, "unfaulted pin");
    rd(pwmdb_pkg::A_STATUS, d);
    chk(32'(d[0]), 32'h1, "fault status");
    chk(32'(nfirq), 32'h1, "fault interrupt");
    wr(pwmdb_pkg::A_INVERT, 32'h3);
    win(16);
    chk(32'(hi[0]), 32'h10, "inverted faulted pin");
    chk(32'(hi[1]), 32'h0, "inverted pin");
    wr(pwmdb_pkg::A_ENABLE, 32'h3c);
    win(16);
    chk(32'(hi[0]), 32'h0, "disabled pin");
    $display("test fault done");

    rst();
    gen(0, 32'h1, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1);
    @(posedge i_clk);
    i_stall <= 1'b1;
    repeat (30) @(posedge i_clk);
    rd(adr(0, pwmdb_pkg::O_COUNT), d);
    chk(d, 32'h0, "halted at zero");
    nxt(0, a);
    chk(32'(a), 32'd200, "no interrupt while halted");
    wr(adr(0, pwmdb_pkg::O_CTL), 32'h5);
    rd(adr(0, pwmdb_pkg::O_COUNT), c0);
    rd(adr(0, pwmdb_pkg::O_COUNT), d);
    chk(d, (c0 + 32'h6) % 32'h8, "keeps counting in stall");
    $display("test stall done");
    complete_run();
  end
endmodule // tb
